// ===== logic/fpm_mac_unit.sv
// fixed-point multiply-accumulate and filter expression unit with apb register access
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "fpm_defines.svh"

module fpm_mac_unit #(
    parameter int ADDR_W = 8
) (
    input  wire logic              SYS_CLK,
    input  wire logic              RESET,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    output logic                   COMPLETION_IRQ
);

    fpm_pkg::fpm_state_e state;

    // operand[0..2] are the coefficients, operand[3] the current sample
    fpm_pkg::fpm_word_t  operand [0:3];
    fpm_pkg::fpm_word_t  previous_sample;
    fpm_pkg::fpm_word_t  older_sample;
    fpm_pkg::fpm_word_t  accumulator;

    logic [1:0]  operand_select;
    logic        half_select;
    logic        completion_irq_enable;
    logic        done_flag;
    logic        mul_overflow;
    logic        acc_overflow;
    logic        expr_mode;
    logic [1:0]  term;

    logic [5:0]  reg_index;
    logic        addr_ok;
    logic        hit_low;
    logic        hit_high;
    logic        hit_ctrl;
    logic        setup_phase;
    logic        wr_commit;
    logic        ctrl_wr;
    logic        low_wr;
    logic        high_wr;
    logic        busy;
    logic        start_ok;
    logic        clear_acc;
    logic        clear_hist;
    logic        load_acc;
    logic        finish;
    logic        mul_load;
    logic        mul_last;
    logic [63:0] product;
    logic [31:0] coeff_sel;
    logic [31:0] sample_sel;
    logic [31:0] next_acc;
    logic        add_ovf;
    logic        prod_ovf;
    logic [7:0]  ctrl_read;
    logic [7:0]  next_rdata;
    logic [7:0]  wbyte;

    assign reg_index   = PADDR[7:2];
    assign addr_ok     = (PADDR[1:0] == 2'h0);
    assign hit_low     = addr_ok && (reg_index == `FPM_IDX_PORT_LOW);
    assign hit_high    = addr_ok && (reg_index == `FPM_IDX_PORT_HIGH);
    assign hit_ctrl    = addr_ok && (reg_index == `FPM_IDX_CTRL);
    assign setup_phase = PSEL && !PENABLE;
    // writes act only at the access edge the master samples pready on
    assign wr_commit   = PSEL && PENABLE && PREADY && PWRITE;
    assign ctrl_wr     = wr_commit && hit_ctrl;
    assign low_wr      = wr_commit && hit_low;
    assign high_wr     = wr_commit && hit_high;
    assign wbyte       = PWDATA[7:0];

    assign busy        = (state != fpm_pkg::FPM_IDLE);
    assign start_ok    = ctrl_wr && wbyte[`FPM_BIT_START] && !busy;
    assign clear_acc   = ctrl_wr && wbyte[`FPM_BIT_OVF_CLRY] && !wbyte[`FPM_BIT_BUSY_CLRX];
    assign clear_hist  = ctrl_wr && wbyte[`FPM_BIT_BUSY_CLRX] && !wbyte[`FPM_BIT_OVF_CLRY];
    assign load_acc    = ctrl_wr && wbyte[`FPM_BIT_OVF_CLRY] && wbyte[`FPM_BIT_BUSY_CLRX];

    assign finish      = ((state == fpm_pkg::FPM_ADD) && !expr_mode)
                      || ((state == fpm_pkg::FPM_NEXT) && (term == `FPM_EXPR_TERMS));
    assign mul_load    = start_ok
                      || ((state == fpm_pkg::FPM_NEXT) && (term != `FPM_EXPR_TERMS));

    // term select; at start the term counter is forced back to the first product
    always_comb begin
        coeff_sel  = operand[0];
        sample_sel = operand[3];
        if (!start_ok) begin
            unique case (term)
                2'h1: begin
                    coeff_sel  = operand[1];
                    sample_sel = previous_sample;
                end
                2'h2: begin
                    coeff_sel  = operand[2];
                    sample_sel = older_sample;
                end
                default: begin
                    coeff_sel  = operand[0];
                    sample_sel = operand[3];
                end
            endcase
        end
    end

    fpm_booth_mul u_mul (
        .clk       (SYS_CLK),
        .reset     (RESET),
        .load      (mul_load),
        .mcand     (coeff_sel),
        .mplier    (sample_sel),
        .product   (product),
        .last_step (mul_last)
    );

    // a product is kept as its low word; any lost significance flags overflow
    assign prod_ovf = !((&product[63:31]) || !(|product[63:31]));

    fpm_acc_adder u_add (
        .acc      (accumulator),
        .addend   (product[31:0]),
        .sum      (next_acc),
        .overflow (add_ovf)
    );

    // sequencer: mac is 16 steps plus add, expression is three of
    // 16 steps, add and a select cycle; the last select cycle shifts history
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            state <= fpm_pkg::FPM_IDLE;
        end else begin
            unique case (state)
                fpm_pkg::FPM_IDLE: begin
                    if (start_ok) begin
                        state <= fpm_pkg::FPM_MUL;
                    end
                end
                fpm_pkg::FPM_MUL: begin
                    if (mul_last) begin
                        state <= fpm_pkg::FPM_ADD;
                    end
                end
                fpm_pkg::FPM_ADD: begin
                    state <= expr_mode ? fpm_pkg::FPM_NEXT : fpm_pkg::FPM_IDLE;
                end
                fpm_pkg::FPM_NEXT: begin
                    state <= (term == `FPM_EXPR_TERMS) ? fpm_pkg::FPM_IDLE : fpm_pkg::FPM_MUL;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            expr_mode <= 1'b0;
            term      <= 2'h0;
        end else if (start_ok) begin
            // the half bit of the starting write picks the operation, not the stale one
            expr_mode <= !wbyte[`FPM_BIT_HALF];
            term      <= 2'h0;
        end else if (state == fpm_pkg::FPM_ADD) begin
            term <= term + 2'h1;
        end
    end

    // accumulator: only the sequencer, clear and load-from-sample touch it
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            accumulator <= `FPM_RST_WORD;
        end else if (load_acc) begin
            accumulator <= operand[3];
        end else if (clear_acc) begin
            accumulator <= `FPM_RST_WORD;
        end else if (state == fpm_pkg::FPM_ADD) begin
            accumulator <= next_acc;
        end
    end

    // sticky overflow flags; a fresh overflow wins over a clear in the same cycle
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            mul_overflow <= 1'b0;
            acc_overflow <= 1'b0;
        end else if ((state == fpm_pkg::FPM_ADD) && (prod_ovf || add_ovf)) begin
            mul_overflow <= mul_overflow || prod_ovf;
            acc_overflow <= acc_overflow || add_ovf;
        end else if (clear_acc || load_acc) begin
            mul_overflow <= 1'b0;
            acc_overflow <= 1'b0;
        end
    end

    // coefficient and current sample registers, byte-wise through the ports
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_operand
            logic sel_hit;
            assign sel_hit = (operand_select == 2'(gi));
            always_ff @(posedge SYS_CLK) begin
                if (RESET) begin
                    operand[gi] <= `FPM_RST_WORD;
                end else if ((gi == 3) && clear_hist) begin
                    operand[gi] <= `FPM_RST_WORD;
                end else if (sel_hit && low_wr) begin
                    if (half_select) begin
                        operand[gi][23:16] <= wbyte;
                    end else begin
                        operand[gi][7:0] <= wbyte;
                    end
                end else if (sel_hit && high_wr) begin
                    if (half_select) begin
                        operand[gi][31:24] <= wbyte;
                    end else begin
                        operand[gi][15:8] <= wbyte;
                    end
                end
            end
        end
    endgenerate

    // history has no write path; shift at expression end beats a clear
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            previous_sample <= `FPM_RST_WORD;
            older_sample    <= `FPM_RST_WORD;
        end else if (finish && expr_mode) begin
            previous_sample <= operand[3];
            older_sample    <= previous_sample;
        end else if (clear_hist) begin
            previous_sample <= `FPM_RST_WORD;
            older_sample    <= `FPM_RST_WORD;
        end
    end

    // control fields
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            operand_select        <= `FPM_RST_SEL;
            half_select           <= 1'b0;
            completion_irq_enable <= 1'b0;
        end else if (ctrl_wr) begin
            operand_select        <= {wbyte[`FPM_BIT_SEL_HI], wbyte[`FPM_BIT_SEL_LO]};
            half_select           <= wbyte[`FPM_BIT_HALF];
            completion_irq_enable <= wbyte[`FPM_BIT_IRQ_EN];
        end
    end

    // completion flag; set at end beats a software clear in the same cycle
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            done_flag <= 1'b0;
        end else if (finish && completion_irq_enable) begin
            done_flag <= 1'b1;
        end else if (ctrl_wr && !wbyte[`FPM_BIT_DONE]) begin
            done_flag <= 1'b0;
        end
    end

    // irq mirrors the flag gated by the enable one cycle late, keeping the output on a flop
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            COMPLETION_IRQ <= 1'b0;
        end else begin
            COMPLETION_IRQ <= done_flag && completion_irq_enable;
        end
    end

    always_comb begin
        ctrl_read                      = 8'h00;
        ctrl_read[`FPM_BIT_OVF_CLRY]   = mul_overflow || acc_overflow;
        ctrl_read[`FPM_BIT_BUSY_CLRX]  = busy;
        ctrl_read[`FPM_BIT_IRQ_EN]     = completion_irq_enable;
        ctrl_read[`FPM_BIT_DONE]       = done_flag;
        ctrl_read[`FPM_BIT_SEL_LO]     = operand_select[0];
        ctrl_read[`FPM_BIT_SEL_HI]     = operand_select[1];
        ctrl_read[`FPM_BIT_HALF]       = half_select;
    end

    // ports read the accumulator only, whatever operand is selected
    always_comb begin
        next_rdata = 8'h00;
        if (hit_ctrl) begin
            next_rdata = ctrl_read;
        end else if (hit_low) begin
            next_rdata = half_select ? accumulator[23:16] : accumulator[7:0];
        end else if (hit_high) begin
            next_rdata = half_select ? accumulator[31:24] : accumulator[15:8];
        end
    end

    // apb slave: data captured in setup, one access cycle, ready from a flop
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else if (setup_phase) begin
            PREADY  <= 1'b1;
            PSLVERR <= !(hit_ctrl || hit_low || hit_high);
            PRDATA  <= PWRITE ? 32'h0000_0000 : {24'h00_0000, next_rdata};
        end else begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end

endmodule : fpm_mac_unit

// ===== logic/fpm_defines.svh
// register indices, control bit positions and timing counts of the arithmetic unit
`ifndef FPM_DEFINES_SVH
`define FPM_DEFINES_SVH

// register index; byte address on the bus is four times the index
`define FPM_IDX_PORT_LOW   6'h3B
`define FPM_IDX_PORT_HIGH  6'h3C
`define FPM_IDX_CTRL       6'h3D

// arith_control bit positions
`define FPM_BIT_START      0
`define FPM_BIT_OVF_CLRY   1
`define FPM_BIT_BUSY_CLRX  2
`define FPM_BIT_IRQ_EN     3
`define FPM_BIT_DONE       4
`define FPM_BIT_SEL_LO     5
`define FPM_BIT_SEL_HI     6
`define FPM_BIT_HALF       7

// reset values
`define FPM_RST_WORD       32'h0000_0000
`define FPM_RST_SEL        2'h0

// timing: last radix-4 step count of a product (steps minus one), terms per full expression
`define FPM_MUL_STEPS      4'hF
`define FPM_EXPR_TERMS     2'h3

`endif

// ===== logic/fpm_pkg.sv
// types shared by the arithmetic unit modules
package fpm_pkg;

    typedef enum logic [1:0] {
        FPM_IDLE = 2'b00,
        FPM_MUL  = 2'b01,
        FPM_ADD  = 2'b10,
        FPM_NEXT = 2'b11
    } fpm_state_e;

    typedef logic [31:0] fpm_word_t;

endpackage : fpm_pkg

// ===== logic/fpm_booth_mul.sv
// sequential radix-4 booth multiplier, signed 32 x 32, sixteen steps
`timescale 1ns/1ps
`include "fpm_defines.svh"

module fpm_booth_mul (
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          load,
    input  wire logic [31:0]   mcand,
    input  wire logic [31:0]   mplier,
    output logic      [63:0]   product,
    output logic               last_step
);

    logic [33:0] hi;
    logic [31:0] lo;
    logic        q;
    logic [3:0]  cnt;
    logic        running;
    logic [33:0] m1;
    logic [33:0] m2;
    logic [33:0] addend;
    logic [33:0] sum;
    logic [31:0] mc;

    assign m1 = {{2{mc[31]}}, mc};
    assign m2 = {mc[31], mc, 1'b0};

    always_comb begin
        unique case ({lo[1:0], q})
            3'h1, 3'h2: addend = m1;
            3'h3:       addend = m2;
            3'h4:       addend = 34'h0 - m2;
            3'h5, 3'h6: addend = 34'h0 - m1;
            default:    addend = 34'h0;
        endcase
        sum = hi + addend;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            hi      <= 34'h0;
            lo      <= 32'h0;
            q       <= 1'b0;
            mc      <= 32'h0;
            cnt     <= 4'h0;
            running <= 1'b0;
        end else if (load) begin
            hi      <= 34'h0;
            lo      <= mplier;
            q       <= 1'b0;
            mc      <= mcand;
            cnt     <= 4'h0;
            running <= 1'b1;
        end else if (running) begin
            // arithmetic shift of {sum, lo, q} right by two
            hi  <= {sum[33], sum[33], sum[33:2]};
            lo  <= {sum[1:0], lo[31:2]};
            q   <= lo[1];
            cnt <= cnt + 4'h1;
            if (cnt == `FPM_MUL_STEPS) begin
                running <= 1'b0;
            end
        end
    end

    assign product   = {hi[31:0], lo};
    assign last_step = running && (cnt == `FPM_MUL_STEPS);

endmodule : fpm_booth_mul

// ===== logic/fpm_acc_adder.sv
// signed 32-bit accumulate adder with two's complement overflow detect
`timescale 1ns/1ps

module fpm_acc_adder (
    input  wire logic [31:0] acc,
    input  wire logic [31:0] addend,
    output logic      [31:0] sum,
    output logic             overflow
);

    assign sum      = acc + addend;
    // overflow only when both inputs share a sign the result lacks
    assign overflow = (acc[31] == addend[31]) && (sum[31] != acc[31]);

endmodule : fpm_acc_adder

// ===== sim/fpm_mac_unit_asserts.sv
// concurrent checks on the arithmetic unit ports
`timescale 1ns/1ps
`include "fpm_defines.svh"

module fpm_mac_unit_asserts #(
    parameter int ADDR_W = 8
) (
    input wire logic              SYS_CLK,
    input wire logic              RESET,
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0]       PWDATA,
    input wire logic [31:0]       PRDATA,
    input wire logic              PREADY,
    input wire logic              PSLVERR,
    input wire logic              COMPLETION_IRQ
);
    logic       en;
    logic       en_d;
    logic [5:0] cnt;
    logic       wctl;
    logic       mapped;

    assign mapped = PADDR == ADDR_W'({`FPM_IDX_PORT_LOW, 2'b00}) || PADDR == ADDR_W'({`FPM_IDX_PORT_HIGH, 2'b00})
                    || PADDR == ADDR_W'({`FPM_IDX_CTRL, 2'b00});
    assign wctl = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR && PADDR == ADDR_W'({`FPM_IDX_CTRL, 2'b00});

    // shadow of the enable bit, one copy delayed to cover the registered request
    always_ff @(posedge SYS_CLK) begin
        if (RESET) en <= 1'b0;
        else if (wctl) en <= PWDATA[`FPM_BIT_IRQ_EN];
    end
    always_ff @(posedge SYS_CLK) begin
        en_d <= RESET ? 1'b0 : en;
    end
    // remaining busy cycles; a start while counting is ignored, as the unit must do
    always_ff @(posedge SYS_CLK) begin
        if (RESET) cnt <= 6'h00;
        else if (wctl && PWDATA[`FPM_BIT_START] && cnt == 6'h00) cnt <= PWDATA[`FPM_BIT_HALF] ? 6'h11 : 6'h36;
        else if (cnt != 6'h00) cnt <= cnt - 6'h01;
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    chk_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready after setup");
    chk_ready_one_cycle: assert property (PREADY |=> !PREADY) else $error("ready held too long");
    chk_ready_in_access: assert property (PREADY |-> PSEL && PENABLE) else $error("ready outside access");
    chk_err_decode: assert property (PREADY |-> PSLVERR == !mapped) else $error("slave error decode wrong");
    chk_rdata_byte_wide: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h000000)
        else $error("read data upper bits set");
    chk_rdata_hold: assert property (!(PSEL && !PENABLE) |=> $stable(PRDATA)) else $error("read data moved");
    chk_irq_masked: assert property (!en && !en_d |-> !COMPLETION_IRQ)
        else $error("interrupt while disabled");
    chk_irq_at_end: assert property ($rose(COMPLETION_IRQ) |-> $past(cnt, 2) == 6'h01)
        else $error("interrupt at wrong cycle");

    cov_irq: cover property ($rose(COMPLETION_IRQ));
    cov_err: cover property (PREADY && PSLVERR);
    cov_mac: cover property (wctl && PWDATA[`FPM_BIT_START] && PWDATA[`FPM_BIT_HALF]);
    cov_expr: cover property (wctl && PWDATA[`FPM_BIT_START] && !PWDATA[`FPM_BIT_HALF]);
endmodule : fpm_mac_unit_asserts

bind fpm_mac_unit fpm_mac_unit_asserts #(.ADDR_W(ADDR_W)) u_fpm_mac_unit_asserts (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .COMPLETION_IRQ(COMPLETION_IRQ));

// ===== sim/fpm_host.sv
// apb master model of the host core
`timescale 1ns/1ps

module fpm_host (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic err;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        err = 1'b0;
    end

    // request held until ready is sampled; the bench timeout ends a hang
    task xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : fpm_host

// ===== sim/fpm_mac_unit_tb.sv
// self-checking bench of the arithmetic unit
`timescale 1ns/1ps
`include "fpm_defines.svh"

module fpm_mac_unit_tb;
    localparam logic [7:0] A_LO = {`FPM_IDX_PORT_LOW, 2'b00};
    localparam logic [7:0] A_HI = {`FPM_IDX_PORT_HIGH, 2'b00};
    localparam logic [7:0] A_CT = {`FPM_IDX_CTRL, 2'b00};
    logic        SYS_CLK = 1'b0;
    logic        RESET = 1'b1;
    logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR, COMPLETION_IRQ;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA, q, v;
    int          err_count = 0;
    int          n_checks = 0;
    int          cyc = 0;
    logic [31:0] exp_acc [4] = '{32'h0000_0079, 32'h0000_008E, 32'h0000_0095, 32'h0000_00BF};

    always #20 SYS_CLK = ~SYS_CLK;

    fpm_mac_unit #(.ADDR_W(8)) u_fpm_mac_unit (.SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .COMPLETION_IRQ(COMPLETION_IRQ));
    fpm_host u_fpm_host (.clk(SYS_CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR),
        .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR));

    task close_out;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // every control write also clears the completion flag
    function automatic logic [7:0] cw(logic h, logic e, logic [2:0] op);
        return {h, 2'b11, 1'b0, e, op};
    endfunction : cw

    task wr(input logic [7:0] a, input logic [7:0] d);
        u_fpm_host.xfer(1'b1, a, d, q);
    endtask : wr

    task ld(input logic [1:0] s, input logic [31:0] w);
        for (int h = 0; h < 2; h++) begin
            wr(A_CT, {h[0], s, 5'h08});
            wr(A_LO, w[16*h +: 8]);
            wr(A_HI, w[16*h+8 +: 8]);
        end
    endtask : ld

    task rdacc(output logic [31:0] w);
        for (int h = 0; h < 2; h++) begin
            wr(A_CT, cw(h[0], 1'b1, 3'h0));
            u_fpm_host.xfer(1'b0, A_LO, 8'h00, q);
            w[16*h +: 8] = q[7:0];
            u_fpm_host.xfer(1'b0, A_HI, 8'h00, q);
            w[16*h+8 +: 8] = q[7:0];
        end
    endtask : rdacc

    task run(input logic h, input logic e, input logic [31:0] exp);
        int k;
        wr(A_CT, cw(h, e, 3'h1));
        wr(A_CT, cw(h, e, 3'h1));
        u_fpm_host.xfer(1'b0, A_CT, 8'h00, q);
        chk("busy", q[2], 1'b1);
        k = 0;
        while (q[2] !== 1'b0 && k < 100) begin
            u_fpm_host.xfer(1'b0, A_CT, 8'h00, q);
            k++;
        end
        chk("idle", q[2], 1'b0);
        chk("flag", q[4], e);
        repeat (2) @(posedge SYS_CLK);
        chk("irq", COMPLETION_IRQ, e);
        rdacc(v);
        chk("acc", v, exp);
    endtask : run

    always @(posedge SYS_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            close_out;
        end
    end

    initial begin
        repeat (5) @(posedge SYS_CLK);
        RESET <= 1'b0;
        u_fpm_host.xfer(1'b0, A_CT, 8'h00, q);
        chk("ctrl", q & 32'h16, 32'h0);
        ld(2'h3, 32'h0000_0064);
        wr(A_CT, cw(1'b0, 1'b1, 3'h6));
        rdacc(v);
        chk("load", v, 32'h0000_0064);
        ld(2'h0, 32'h0000_0003);
        ld(2'h1, 32'hFFFF_FFFE);
        ld(2'h2, 32'h0000_0005);
        ld(2'h3, 32'h0000_0007);
        // mac first, so an unwanted history shift would change all later sums
        for (int i = 0; i < 4; i++) run(i == 0, i != 3, exp_acc[i]);
        wr(A_CT, cw(1'b0, 1'b1, 3'h4));
        run(1'b0, 1'b1, 32'h0000_00BF);
        wr(A_CT, cw(1'b0, 1'b1, 3'h2));
        rdacc(v);
        chk("clear", v, 32'h0);
        ld(2'h0, 32'h7FFF_FFFF);
        ld(2'h3, 32'h0000_0002);
        run(1'b1, 1'b1, 32'hFFFF_FFFE);
        u_fpm_host.xfer(1'b0, A_CT, 8'h00, q);
        chk("mul ovf", q[1], 1'b1);
        wr(A_CT, cw(1'b0, 1'b1, 3'h2));
        u_fpm_host.xfer(1'b0, A_CT, 8'h00, q);
        chk("ovf clr", q[1], 1'b0);
        ld(2'h0, 32'h0000_0001);
        ld(2'h3, 32'h7FFF_FFFF);
        wr(A_CT, cw(1'b0, 1'b1, 3'h6));
        ld(2'h3, 32'h0000_0001);
        run(1'b1, 1'b1, 32'h8000_0000);
        u_fpm_host.xfer(1'b0, A_CT, 8'h00, q);
        chk("acc ovf", q[1], 1'b1);
        foreach (exp_acc[i]) begin
            u_fpm_host.xfer(1'b0, 8'h00 + 8'(i) * 8'h75, 8'h00, q);
            chk("unmapped", {q[30:0], u_fpm_host.err}, 32'h1);
        end
        close_out;
    end
endmodule : fpm_mac_unit_tb
